// file: hw/freq_select_ctrl.sv
// Design decisions made here: the address map and the AXI4-Lite slave port.
`timescale 1ns/100ps
// Function
// - The active five-bit code picks a CPU, mid group and PCI frequency from a fixed 32-entry table.
// - In programmable mode only CPU frequencies from 50 MHz to 248 MHz are accepted.
// - The programmable enable bit resets to 0 and writing 1 turns programmable mode on.
// - With programmable mode off and override clear, the latched strap code sets the frequencies.
// - With programmable mode off and override set, the software code sets the frequencies.
// - With programmable mode on, the CPU frequency comes from the programmed N, M and gear constant.
// - In programmable mode the ratio follows the software code under override, else the strap code; the gear constant is fixed.
// - A watchdog time-out asserts a system reset and switches to the recovery frequency.
// - The recovery source bit picks the strap code at 0 and the recovery N and M at 1.
// - In programmable mode any update of N or M starts loading a new CPU frequency.
module freq_select_ctrl (
  input  wire logic                               clk_sys,
  input  wire logic                               arst_n,
  input  wire logic [freq_sel_pkg::ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                               s_axi_awvalid,
  output      logic                               s_axi_awready,
  input  wire logic [31:0]                        s_axi_wdata,
  input  wire logic [3:0]                         s_axi_wstrb,
  input  wire logic                               s_axi_wvalid,
  output      logic                               s_axi_wready,
  output      logic [1:0]                         s_axi_bresp,
  output      logic                               s_axi_bvalid,
  input  wire logic                               s_axi_bready,
  input  wire logic [freq_sel_pkg::ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                               s_axi_arvalid,
  output      logic                               s_axi_arready,
  output      logic [31:0]                        s_axi_rdata,
  output      logic [1:0]                         s_axi_rresp,
  output      logic                               s_axi_rvalid,
  input  wire logic                               s_axi_rready,
  input  wire freq_sel_pkg::freq_code_t           strap_freq_code,
  input  wire logic                               wdog_timeout,
  output      freq_sel_pkg::freq_code_t           freq_code,
  output      logic                               use_dividers,
  output      logic [7:0]                         pll_divider_n,
  output      logic [6:0]                         pll_divider_m,
  output      freq_sel_pkg::tenths_t              cpu_freq_tenths,
  output      freq_sel_pkg::tenths_t              mid_freq_tenths,
  output      freq_sel_pkg::tenths_t              pci_freq_tenths,
  output      logic                               freq_load,
  output      logic                               sys_reset_n,
  output      logic                               irq
);
  import freq_sel_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic                   strap_taken;
  freq_code_t             strap_latched;
  logic                   prog_en;
  logic                   strap_override;
  logic                   recovery_source_select;
  freq_code_t             soft_code;
  logic [7:0]             cpu_divider_n;
  logic [6:0]             cpu_divider_m;
  logic [7:0]             recovery_divider_n;
  logic [6:0]             recovery_divider_m;
  logic                   recovery_active;
  logic                   div_written;
  logic [IRQ_W-1:0]       irq_status;
  logic [IRQ_W-1:0]       irq_mask;
  logic [ADDR_W-1:0]      wr_addr;
  logic [31:0]            wr_data;
  logic [3:0]             wr_strb;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a == OFS_CTRL) || (a == OFS_CPU_DIV) || (a == OFS_RCV_DIV) || (a == OFS_STATUS) ||
             (a == OFS_FREQ) || (a == OFS_IRQ_STAT) || (a == OFS_IRQ_MASK);
  endfunction

  function automatic logic in_range(input logic [7:0] n, input logic [6:0] m);
    logic [39:0] f_scaled;
    logic [39:0] lo;
    logic [39:0] hi;
    f_scaled = 40'(n) * GEAR_E5;
    lo       = 40'(m) * PROG_MIN_MHZ * FREQ_SCALE;
    hi       = 40'(m) * PROG_MAX_MHZ * FREQ_SCALE;
    in_range = (m != 7'h00) && (f_scaled >= lo) && (f_scaled <= hi);
  endfunction

  // ---------------------------------------------------------------
  // Write channel
  // ---------------------------------------------------------------
  wire do_write  = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire [31:0] wmask    = strb_mask(wr_strb);
  wire wr_ctrl   = do_write && (wr_addr == OFS_CTRL);
  wire wr_cpu    = do_write && (wr_addr == OFS_CPU_DIV);
  wire wr_rcv    = do_write && (wr_addr == OFS_RCV_DIV);
  wire wr_istat  = do_write && (wr_addr == OFS_IRQ_STAT);
  wire wr_imask  = do_write && (wr_addr == OFS_IRQ_MASK);

  wire [31:0] ctrl_old = {19'h0, soft_code, 5'h0, recovery_source_select, strap_override, prog_en};
  wire [31:0] cpu_old  = {17'h0, cpu_divider_m, cpu_divider_n};
  wire [31:0] rcv_old  = {17'h0, recovery_divider_m, recovery_divider_n};
  wire [31:0] ctrl_new = (ctrl_old & ~wmask) | (wr_data & wmask);
  wire [31:0] cpu_new  = (cpu_old & ~wmask) | (wr_data & wmask);
  wire [31:0] rcv_new  = (rcv_old & ~wmask) | (wr_data & wmask);
  wire [31:0] mask_new = ({29'h0, irq_mask} & ~wmask) | (wr_data & wmask);

  wire cpu_ok    = in_range(cpu_new[DIV_N_LSB +: 8], cpu_new[DIV_M_LSB +: 7]);
  wire rcv_ok    = in_range(rcv_new[DIV_N_LSB +: 8], rcv_new[DIV_M_LSB +: 7]);
  wire range_err = (wr_cpu && !cpu_ok) || (wr_rcv && !rcv_ok);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      wr_addr       <= '0;
      wr_data       <= 32'h0;
      wr_strb       <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        wr_addr       <= {s_axi_awaddr[ADDR_W-1:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wr_data      <= s_axi_wdata;
        wr_strb      <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(wr_addr) && !range_err ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      prog_en                <= 1'b0;
      strap_override         <= 1'b0;
      recovery_source_select <= 1'b0;
      soft_code              <= RST_SOFT_CODE;
      irq_mask               <= RST_IRQ_MASK;
    end else begin
      if (wr_ctrl) begin
        prog_en                <= ctrl_new[CTRL_PROG_EN];
        strap_override         <= ctrl_new[CTRL_OVERRIDE];
        recovery_source_select <= ctrl_new[CTRL_RCV_SEL];
        soft_code              <= ctrl_new[CTRL_SOFT_LSB +: 5];
      end
      if (wr_imask) begin
        irq_mask <= mask_new[IRQ_W-1:0];
      end
    end
  end

  // Divider pairs share one word so N and M always land together
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cpu_divider_n      <= RST_DIV_N;
      cpu_divider_m      <= RST_DIV_M;
      recovery_divider_n <= RST_DIV_N;
      recovery_divider_m <= RST_DIV_M;
    end else begin
      if (wr_cpu && cpu_ok) begin
        cpu_divider_n <= cpu_new[DIV_N_LSB +: 8];
        cpu_divider_m <= cpu_new[DIV_M_LSB +: 7];
      end
      if (wr_rcv && rcv_ok) begin
        recovery_divider_n <= rcv_new[DIV_N_LSB +: 8];
        recovery_divider_m <= rcv_new[DIV_M_LSB +: 7];
      end
    end
  end

  // ---------------------------------------------------------------
  // Strap capture
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      strap_taken   <= 1'b0;
      strap_latched <= 5'h00;
    end else if (!strap_taken) begin
      strap_taken   <= 1'b1;
      strap_latched <= strap_freq_code;
    end
  end

  // ---------------------------------------------------------------
  // Watchdog recovery
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      recovery_active <= 1'b0;
    end else if (wdog_timeout) begin
      recovery_active <= 1'b1;
    end else if (wr_ctrl) begin
      recovery_active <= 1'b0;
    end
  end

  reset_pulse u_reset_pulse (
    .clk_sys     (clk_sys),
    .arst_n      (arst_n),
    .start       (wdog_timeout),
    .sys_reset_n (sys_reset_n)
  );

  // ---------------------------------------------------------------
  // Source selection
  // ---------------------------------------------------------------
  wire freq_code_t ratio_code   = strap_override ? soft_code : strap_latched;
  wire             rcv_strap    = recovery_active && !recovery_source_select;
  wire freq_code_t next_code    = rcv_strap ? strap_latched : ratio_code;
  wire             next_use_div = recovery_active ? recovery_source_select : prog_en;
  wire [7:0]       next_n       = recovery_active ? recovery_divider_n : cpu_divider_n;
  wire [6:0]       next_m       = recovery_active ? recovery_divider_m : cpu_divider_m;

  tenths_t tbl_cpu;
  tenths_t tbl_mid;
  tenths_t tbl_pci;

  freq_table u_freq_table (
    .code       (next_code),
    .cpu_tenths (tbl_cpu),
    .mid_tenths (tbl_mid),
    .pci_tenths (tbl_pci)
  );

  wire setting_change = (next_code != freq_code) || (next_use_div != use_dividers) ||
                        (next_use_div && ((next_n != pll_divider_n) || (next_m != pll_divider_m)));
  wire div_update     = prog_en && wr_cpu && cpu_ok;
  wire next_load      = setting_change || div_written;

  // Lines up with the setting change
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      div_written <= 1'b0;
    end else begin
      div_written <= div_update;
    end
  end

  // ---------------------------------------------------------------
  // Outputs to the synthesizer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      freq_code       <= 5'h00;
      use_dividers    <= 1'b0;
      pll_divider_n   <= RST_DIV_N;
      pll_divider_m   <= RST_DIV_M;
      cpu_freq_tenths <= 12'h000;
      mid_freq_tenths <= 12'h000;
      pci_freq_tenths <= 12'h000;
      freq_load       <= 1'b0;
    end else begin
      freq_code       <= next_code;
      use_dividers    <= next_use_div;
      pll_divider_n   <= next_n;
      pll_divider_m   <= next_m;
      cpu_freq_tenths <= next_use_div ? 12'h000 : tbl_cpu;
      mid_freq_tenths <= tbl_mid;
      pci_freq_tenths <= tbl_pci;
      freq_load       <= next_load && strap_taken;
    end
  end

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------
  wire [IRQ_W-1:0] irq_set   = {range_err, freq_load, wdog_timeout};
  wire [IRQ_W-1:0] irq_clear = wr_istat ? (wr_data[IRQ_W-1:0] & wmask[IRQ_W-1:0]) : '0;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq_status <= '0;
      irq        <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~irq_clear) | irq_set;
      irq        <= |(irq_status & irq_mask);
    end
  end

  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------
  wire [ADDR_W-1:0] rd_addr = {s_axi_araddr[ADDR_W-1:2], 2'b00};
  wire [31:0] status_word = {14'h0, recovery_active, use_dividers, 3'h0, strap_latched, 3'h0, freq_code};
  wire [31:0] freq_word   = {8'h0, mid_freq_tenths, cpu_freq_tenths};
  wire [31:0] rd_mux =
    (rd_addr == OFS_CTRL)     ? ctrl_old :
    (rd_addr == OFS_CPU_DIV)  ? cpu_old :
    (rd_addr == OFS_RCV_DIV)  ? rcv_old :
    (rd_addr == OFS_STATUS)   ? status_word :
    (rd_addr == OFS_FREQ)     ? freq_word :
    (rd_addr == OFS_IRQ_STAT) ? {29'h0, irq_status} :
    (rd_addr == OFS_IRQ_MASK) ? {29'h0, irq_mask} : 32'h0;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_mux;
        s_axi_rresp   <= mapped(rd_addr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule

// file: hw/freq_sel_pkg.sv
package freq_sel_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS    = 40;
  localparam int unsigned SYS_RESET_NS     = 1000;
  localparam int unsigned SYS_RESET_CYCLES = (SYS_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W        = 8;
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_CPU_DIV   = 8'h04;
  localparam logic [7:0]  OFS_RCV_DIV   = 8'h08;
  localparam logic [7:0]  OFS_STATUS    = 8'h0c;
  localparam logic [7:0]  OFS_FREQ      = 8'h10;
  localparam logic [7:0]  OFS_IRQ_STAT  = 8'h14;
  localparam logic [7:0]  OFS_IRQ_MASK  = 8'h18;

  // CTRL fields
  localparam int unsigned CTRL_PROG_EN  = 0;
  localparam int unsigned CTRL_OVERRIDE = 1;
  localparam int unsigned CTRL_RCV_SEL  = 2;
  localparam int unsigned CTRL_SOFT_LSB = 8;
  // Divider fields (CPU_DIV and RCV_DIV)
  localparam int unsigned DIV_N_LSB     = 0;
  localparam int unsigned DIV_M_LSB     = 8;
  // STATUS fields
  localparam int unsigned ST_CODE_LSB   = 0;
  localparam int unsigned ST_STRAP_LSB  = 8;
  localparam int unsigned ST_USE_DIV    = 16;
  localparam int unsigned ST_RECOVERY   = 17;
  // FREQ fields (tenths of MHz)
  localparam int unsigned FQ_CPU_LSB    = 0;
  localparam int unsigned FQ_MID_LSB    = 12;
  // Interrupt bits
  localparam int unsigned IRQ_WDOG      = 0;
  localparam int unsigned IRQ_LOAD      = 1;
  localparam int unsigned IRQ_RANGE     = 2;
  localparam int unsigned IRQ_W         = 3;

  // Reset values
  localparam logic [4:0]  RST_SOFT_CODE = 5'h00;
  localparam logic [7:0]  RST_DIV_N     = 8'h00;
  localparam logic [6:0]  RST_DIV_M     = 7'h00;
  localparam logic [2:0]  RST_IRQ_MASK  = 3'h0;

  // Programmable range and gear constant, scaled by 1e5
  localparam logic [39:0] FREQ_SCALE    = 40'd100000;
  localparam logic [39:0] GEAR_E5       = 40'd4800741;
  localparam logic [39:0] PROG_MIN_MHZ  = 40'd50;
  localparam logic [39:0] PROG_MAX_MHZ  = 40'd248;

  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;

  typedef logic [4:0]  freq_code_t;
  typedef logic [11:0] tenths_t;

endpackage

// file: hw/freq_table.sv
`timescale 1ns/100ps
module freq_table (
  input  wire freq_sel_pkg::freq_code_t code,
  output      freq_sel_pkg::tenths_t    cpu_tenths,
  output      freq_sel_pkg::tenths_t    mid_tenths,
  output      freq_sel_pkg::tenths_t    pci_tenths
);
  import freq_sel_pkg::*;

  // ---------------------------------------------------------------
  // CPU and mid group per code, tenths of MHz
  // ---------------------------------------------------------------
  function automatic logic [23:0] lookup(input freq_code_t c);
    case (c)
      5'h00: lookup = {12'd1020, 12'd680};
      5'h01: lookup = {12'd1050, 12'd700};
      5'h02: lookup = {12'd1080, 12'd720};
      5'h03: lookup = {12'd1110, 12'd740};
      5'h04: lookup = {12'd1140, 12'd760};
      5'h05: lookup = {12'd1170, 12'd780};
      5'h06: lookup = {12'd1200, 12'd800};
      5'h07: lookup = {12'd1230, 12'd820};
      5'h08: lookup = {12'd1260, 12'd630};
      5'h09: lookup = {12'd1300, 12'd650};
      5'h0a: lookup = {12'd1360, 12'd680};
      5'h0b: lookup = {12'd1400, 12'd700};
      5'h0c: lookup = {12'd1440, 12'd720};
      5'h0d: lookup = {12'd1480, 12'd740};
      5'h0e: lookup = {12'd1520, 12'd760};
      5'h0f: lookup = {12'd1560, 12'd780};
      5'h10: lookup = {12'd1600, 12'd800};
      5'h11: lookup = {12'd1640, 12'd820};
      5'h12: lookup = {12'd1666, 12'd666};
      5'h13: lookup = {12'd1700, 12'd680};
      5'h14: lookup = {12'd1750, 12'd700};
      5'h15: lookup = {12'd1800, 12'd720};
      5'h16: lookup = {12'd1850, 12'd740};
      5'h17: lookup = {12'd1900, 12'd760};
      5'h18: lookup = {12'd668,  12'd668};
      5'h19: lookup = {12'd1002, 12'd668};
      5'h1a: lookup = {12'd1336, 12'd668};
      5'h1b: lookup = {12'd2004, 12'd668};
      5'h1c: lookup = {12'd666,  12'd666};
      5'h1d: lookup = {12'd1000, 12'd666};
      5'h1e: lookup = {12'd2000, 12'd666};
      default: lookup = {12'd1333, 12'd666};
    endcase
  endfunction

  wire [23:0] entry = lookup(code);

  assign cpu_tenths = entry[23:12];
  assign mid_tenths = entry[11:0];
  assign pci_tenths = {1'b0, entry[11:1]}; // PCI is half the mid group
endmodule

// file: hw/reset_pulse.sv
`timescale 1ns/100ps
module reset_pulse (
  input  wire logic clk_sys,
  input  wire logic arst_n,
  input  wire logic start,
  output      logic sys_reset_n
);
  import freq_sel_pkg::*;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_HOLD = 1'b1
  } pulse_state_e;

  pulse_state_e state;
  logic [7:0]   count;

  // ---------------------------------------------------------------
  // Fixed-width system reset pulse
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state       <= ST_IDLE;
      count       <= 8'h00;
      sys_reset_n <= 1'b1;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start) begin
            state       <= ST_HOLD;
            count       <= 8'(SYS_RESET_CYCLES - 1);
            sys_reset_n <= 1'b0;
          end
        end
        ST_HOLD: begin
          if (count == 8'h00) begin
            state       <= ST_IDLE;
            sys_reset_n <= 1'b1;
          end else begin
            count <= count - 8'h01;
          end
        end
        default: begin
          state       <= ST_IDLE;
          sys_reset_n <= 1'b1;
        end
      endcase
    end
  end
endmodule

// file: dv/freq_select_ctrl_sva.sv
`timescale 1ns/100ps
module freq_select_ctrl_sva (
  input wire logic        clk_sys,
  input wire logic        arst_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [4:0]  strap_freq_code,
  input wire logic        wdog_timeout,
  input wire logic [4:0]  freq_code,
  input wire logic        use_dividers,
  input wire logic [11:0] cpu_freq_tenths,
  input wire logic [11:0] mid_freq_tenths,
  input wire logic [11:0] pci_freq_tenths,
  input wire logic        freq_load,
  input wire logic        sys_reset_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // ----------------------------------------
  // Sequences and properties
  // ----------------------------------------
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rst_low;
    ##24 !sys_reset_n ##1 sys_reset_n;
  endsequence
  sequence s_bus_idle;
    s_axi_awready && s_axi_wready && !s_axi_awvalid && !s_axi_wvalid;
  endsequence
  a_write_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_one_bresp: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("extra write answer");
  a_one_rresp: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("extra read answer");
  a_table_ratio: assert property (mid_freq_tenths == {pci_freq_tenths[10:0], 1'b0})
    else $error("pci not half of mid");
  a_div_cpu_zero: assert property (use_dividers |-> cpu_freq_tenths == 12'h000)
    else $error("table cpu value while dividers used");
  a_wdog_reset: assert property (wdog_timeout && sys_reset_n |=> !sys_reset_n)
    else $error("no system reset on timeout");
  a_reset_width: assert property ($fell(sys_reset_n) |-> s_rst_low)
    else $error("system reset width wrong");
  a_load_pulse: assert property (freq_load |=> !freq_load)
    else $error("load pulse too long");
  a_strap_held: assert property ($changed(strap_freq_code) and s_bus_idle and !wdog_timeout
    && !$past(wdog_timeout) |=> $stable(freq_code)) else $error("code followed strap pins");
endmodule

// file: dv/axi_host.sv
`timescale 1ns/100ps
module axi_host (
  input wire logic        clk_sys,
  output     logic [7:0]  s_axi_awaddr,
  output     logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  output     logic [31:0] s_axi_wdata,
  output     logic [3:0]  s_axi_wstrb,
  output     logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  output     logic        s_axi_bready,
  output     logic [7:0]  s_axi_araddr,
  output     logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  output     logic        s_axi_rready
);
  // ----------------------------------------
  // Bus cycles, one of each kind at a time
  // ----------------------------------------
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

// file: dv/freq_select_ctrl_tb.sv
`timescale 1ns/100ps
module freq_select_ctrl_tb;
  import freq_sel_pkg::*;
  logic              clk_sys = 1'b0;
  logic              arst_n = 1'b0;
  logic [7:0]        s_axi_awaddr, s_axi_araddr, pll_divider_n;
  logic [31:0]       s_axi_wdata, s_axi_rdata, d, s;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp, r;
  logic [6:0]        pll_divider_m;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic              wdog_timeout, use_dividers, freq_load, sys_reset_n, irq;
  freq_code_t        strap_freq_code, freq_code, code;
  tenths_t           cpu_freq_tenths, mid_freq_tenths, pci_freq_tenths;
  int                checks = 0, num_errors = 0, loads = 0, n, m, l;
  int cpu_t [32] = '{1020, 1050, 1080, 1110, 1140, 1170, 1200, 1230, 1260, 1300, 1360, 1400, 1440, 1480, 1520,
    1560, 1600, 1640, 1666, 1700, 1750, 1800, 1850, 1900, 668, 1002, 1336, 2004, 666, 1000, 2000, 1333};
  int mid_t [32] = '{680, 700, 720, 740, 760, 780, 800, 820, 630, 650, 680, 700, 720, 740, 760, 780, 800, 820,
    666, 680, 700, 720, 740, 760, 668, 668, 668, 668, 666, 666, 666, 666};
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (freq_load === 1'b1) loads <= loads + 1;
  freq_select_ctrl DUT (.*);
  axi_host host (.*);
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic int ok_div(input int n, input int m);
    return m != 0 && 64'(n) * 4800741 >= 64'(m) * 5000000 && 64'(n) * 4800741 <= 64'(m) * 24800000;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic settle;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  task automatic pulse;
    @(posedge clk_sys) wdog_timeout <= 1'b1;
    @(posedge clk_sys) wdog_timeout <= 1'b0;
    settle;
  endtask
  task automatic results;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #1000000;
    num_errors++;
    results;
  end
  initial begin
    wdog_timeout = 1'b0;
    s = lfsr(32'h2086);
    strap_freq_code = s[4:0];
    code = s[4:0];
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    settle;
    chk(freq_code, code);
    chk(cpu_freq_tenths, cpu_t[code]);
    host.rd(OFS_CTRL, d, r);
    chk(d, 32'h0);
    host.rd(OFS_STATUS, d, r);
    chk(d[12:0], {code, 3'h0, code});
    strap_freq_code <= ~code;
    settle;
    chk(freq_code, code);
    host.rd(8'h1c, d, r);
    chk({r, d[29:0]}, {RESP_SLVERR, 30'h0});
    host.wr(8'h1c, 32'h1, r);
    chk(r, RESP_SLVERR);
    for (int c = 0; c < 32; c++) begin
      host.wr(OFS_CTRL, 32'(c) << 8 | 32'h2, r);
      host.rd(OFS_FREQ, d, r);
      chk(d[23:0], mid_t[c] << 12 | cpu_t[c]);
      chk(pci_freq_tenths, mid_t[c] / 2);
    end
    for (int i = 0; i < 8; i++) begin
      s = lfsr(s);
      n = s[7:0];
      m = (i == 0) ? 0 : s[11:8] + 1;
      host.wr(OFS_CTRL, 32'(~code) << 8 | 32'(i % 2 * 2 + 1), r);
      settle;
      l = loads;
      host.wr(OFS_CPU_DIV, 32'(m << 8 | n), r);
      settle;
      chk(r, ok_div(n, m) ? RESP_OKAY : RESP_SLVERR);
      chk(loads - l, ok_div(n, m));
      chk(mid_freq_tenths, mid_t[i % 2 ? ~code : code]);
      chk({use_dividers, cpu_freq_tenths}, 32'h1000);
      if (ok_div(n, m)) chk({pll_divider_m, pll_divider_n}, 32'(m << 8 | n));
    end
    // Recovery set up before the timeout can fire
    host.wr(OFS_RCV_DIV, 32'h1432, r);
    host.wr(OFS_CTRL, 32'h4, r);
    host.wr(OFS_IRQ_MASK, 32'h7, r);
    host.wr(OFS_IRQ_STAT, 32'h7, r);
    settle;
    chk(irq, 1'b0);
    pulse;
    chk({sys_reset_n, use_dividers, pll_divider_m, pll_divider_n, irq}, 32'h012865);
    host.rd(OFS_STATUS, d, r);
    chk(d[17:16], 2'b11);
    host.wr(OFS_IRQ_MASK, 32'h0, r);
    host.wr(OFS_CTRL, 32'h0, r);
    repeat (30) @(posedge clk_sys);
    pulse;
    chk({sys_reset_n, use_dividers, freq_code, irq}, {26'h0, code, 1'b0});
    host.wr(OFS_IRQ_MASK, 32'h1, r);
    settle;
    chk(irq, 1'b1);
    host.wr(OFS_IRQ_STAT, 32'h7, r);
    settle;
    chk(irq, 1'b0);
    results;
  end
endmodule
bind freq_select_ctrl freq_select_ctrl_sva chk_sva (.*);
